/* common/demod_cfg_pkg.sv */
// Package: register map, field positions, reset values and carrier types of the config bank
`default_nettype none
package demod_cfg_pkg;
  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [14:0] ADDR_SERIAL_IF = 15'h0000;
  localparam logic [14:0] ADDR_CHIP_REV = 15'h0006;
  localparam logic [14:0] ADDR_COEF_STROBE = 15'h0010;
  localparam logic [14:0] ADDR_COEF_FIRST = 15'h0011;
  localparam logic [14:0] ADDR_COEF_LAST = 15'h0027;
  localparam logic [14:0] ADDR_ANALOG_PIN = 15'h0028;
  localparam logic [14:0] ADDR_SYNC_OUT = 15'h0029;
  localparam logic [14:0] ADDR_MIXER = 15'h002A;
  localparam logic [14:0] ADDR_CLK_DIV = 15'h002B;
  localparam logic [14:0] ADDR_DIG_PIN = 15'h002C;
  localparam logic [14:0] ADDR_CORE_RESET = 15'h002D;
  localparam logic [14:0] ADDR_CHECKSUM = 15'h002E;
  localparam logic [14:0] ADDR_BOOT_STATUS = 15'h002F;
  localparam int NUM_COEF = 23;
  // ***************************************************************
  // Serial-interface field positions
  // ***************************************************************
  localparam int SIF_SOFT_RESET = 7;
  localparam int SIF_LSB_FIRST = 6;
  localparam int SIF_ADDR_INC = 5;
  localparam int SIF_FOUR_WIRE = 4;
  // ***************************************************************
  // Writable-bit masks and reset values
  // ***************************************************************
  localparam logic [7:0] MASK_COEF_STROBE = 8'h03;
  localparam logic [7:0] MASK_ANALOG_PIN = 8'h03;
  localparam logic [7:0] MASK_SYNC_OUT = 8'h3F;
  localparam logic [7:0] MASK_MIXER = 8'h5F;
  localparam logic [7:0] MASK_CLK_DIV = 8'h1F;
  localparam logic [7:0] MASK_DIG_PIN = 8'h01;
  localparam logic [7:0] MASK_CORE_RESET = 8'h01;
  localparam logic [7:0] RST_SERIAL_IF = 8'h00;
  localparam logic [7:0] RST_COEF_STROBE = 8'h00;
  localparam logic [7:0] RST_ANALOG_PIN = 8'h00;
  localparam logic [7:0] RST_SYNC_OUT = 8'h2D;
  localparam logic [7:0] RST_MIXER = 8'h18;
  localparam logic [7:0] RST_CLK_DIV = 8'h02;
  localparam logic [7:0] RST_DIG_PIN = 8'h01;
  localparam logic [7:0] RST_CORE_RESET = 8'h00;
  // Coefficient defaults, index 0 is offset 0x0011
  localparam logic [NUM_COEF*8-1:0] RST_COEF = {
    8'h00, 8'h00, 8'h00, 8'hE0, 8'h00, 8'h0F, 8'hC0, 8'h0F, 8'hC0, 8'h0F, 8'hC0,
    8'h88, 8'h7E, 8'h97, 8'h1D, 8'h0F, 8'hC0, 8'h0F, 8'hC0, 8'hD7, 8'h1D,
    8'h00, 8'h00};
  // ***************************************************************
  // Carrier types
  // ***************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [14:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic done;
    logic [7:0] checksum;
    logic ok;
    logic timeout;
  } boot_result_t;

  typedef struct packed {
    logic [7:0] serial_if;
    logic [7:0] coef_strobe;
    logic [NUM_COEF*8-1:0] coef;
    logic [NUM_COEF*8-1:0] active_coef;
    logic [7:0] analog_pin;
    logic [7:0] sync_out;
    logic [7:0] mixer;
    logic [7:0] clk_div;
    logic [7:0] dig_pin;
    logic [7:0] core_reset;
    logic [7:0] checksum;
    logic [2:0] boot_status;
    logic [7:0] rdata;
    logic coef_load;
  } bank_state_t;
endpackage
`default_nettype wire

/* logic/demod_config_register_bank.sv */
// Configuration register bank of the synchronous demodulator, byte-wide access from the serial port
// Summary of operation
// [R1] Writing one to serial-interface bit 7 holds the device in reset until zero is written.
// [R2] While soft reset is held, every configuration register except the serial-interface byte returns to its default.
// [R3] Serial-interface bit 6 picks bit order: zero MSB first, one LSB first.
// [R4] Serial-interface bit 5 sets multibyte address direction: zero decrement, one increment.
// [R5] Bit 4 zero: data pin bidirectional, separate output off; one: separate output drives.
// [R6] Serial-interface bits 3..0 mirror bits 4..7 so the byte reads symmetric.
// [R7] Coefficient strobe moving zero to one copies coefficient registers into the active filter.
// [R8] Checksum register returns the checksum computed during the latest boot load.
// [R9] Boot status bit 0 is one on completion, zero on timeout; bits 1,2 pass/fail.
// [R10] Unused and don't-care bits ignore writes and read as zero.
`default_nettype none
module demod_config_register_bank #(
  parameter logic [3:0] DIE_REVISION = 4'h5 // Arbitrary value
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Byte requests from the serial front end and the boot loader result
  input wire demod_cfg_pkg::reg_req_t req_i,
  input wire demod_cfg_pkg::boot_result_t boot_i,
  // Read byte and serial-interface controls
  output logic [7:0] rdata_o,
  output logic soft_reset_o,
  output logic lsb_first_o,
  output logic addr_increment_o,
  output logic four_wire_select_o,
  output logic data_pin_bidir_o,
  // Filter and configuration contents
  output logic [demod_cfg_pkg::NUM_COEF*8-1:0] active_coef_o,
  output logic coef_load_o,
  output logic [7:0] analog_pin_o,
  output logic [7:0] sync_out_o,
  output logic [7:0] mixer_o,
  output logic [7:0] clk_div_o,
  output logic [7:0] dig_pin_o,
  output logic core_reset_o
);
  // ***************************************************************
  // State
  // ***************************************************************
  demod_cfg_pkg::bank_state_t s;
  demod_cfg_pkg::bank_state_t next_s;
  logic [4:0] coef_idx;
  logic [demod_cfg_pkg::NUM_COEF-1:0] coef_hit;
  logic coef_range;
  logic [7:0] strobe_wdata;
  logic strobe_rise;
  logic hold_soft_reset;

  // Symmetric control byte from the four upper control bits
  function automatic logic [7:0] mirror_sif(input logic [7:0] d);
    mirror_sif = {d[7:4], d[4], d[5], d[6], d[7]}; // [R6]
  endfunction

  // ***************************************************************
  // Address decode
  // ***************************************************************
  // One comparator per coefficient byte; the index is only used inside the range
  for (genvar k = 0; k < demod_cfg_pkg::NUM_COEF; k++) begin : g_coef_hit
    assign coef_hit[k] = req_i.addr == demod_cfg_pkg::ADDR_COEF_FIRST + 15'(k);
  end
  assign coef_range = |coef_hit;
  assign coef_idx = 5'(req_i.addr - demod_cfg_pkg::ADDR_COEF_FIRST);

  // Load fires only when the strobe field leaves all-zero
  assign strobe_wdata = req_i.wdata & demod_cfg_pkg::MASK_COEF_STROBE;
  assign strobe_rise = s.coef_strobe == 8'h00 && strobe_wdata != 8'h00; // [R7]

  // Soft reset stays until a serial-interface write clears bit 7
  assign hold_soft_reset = s.serial_if[demod_cfg_pkg::SIF_SOFT_RESET] && // [R1]
    !(req_i.wr && req_i.addr == demod_cfg_pkg::ADDR_SERIAL_IF &&
      !req_i.wdata[demod_cfg_pkg::SIF_SOFT_RESET]);

  // ***************************************************************
  // Next-state logic
  // ***************************************************************
  always_comb begin
    next_s = s;
    next_s.coef_load = 1'b0;
    next_s.rdata = 8'h00;
    // ***************************************************************
    // Register writes
    // ***************************************************************
    if (req_i.wr) begin
      unique case (req_i.addr)
        demod_cfg_pkg::ADDR_SERIAL_IF: begin
          next_s.serial_if = mirror_sif(req_i.wdata); // [R1] [R3] [R4] [R5] [R6]
        end
        demod_cfg_pkg::ADDR_COEF_STROBE: begin
          next_s.coef_strobe = strobe_wdata; // [R10]
          if (strobe_rise) begin
            next_s.active_coef = s.coef; // [R7]
            next_s.coef_load = 1'b1; // [R7]
          end
        end
        demod_cfg_pkg::ADDR_ANALOG_PIN: begin
          next_s.analog_pin = req_i.wdata & demod_cfg_pkg::MASK_ANALOG_PIN; // [R10]
        end
        demod_cfg_pkg::ADDR_SYNC_OUT: begin
          next_s.sync_out = req_i.wdata & demod_cfg_pkg::MASK_SYNC_OUT; // [R10]
        end
        demod_cfg_pkg::ADDR_MIXER: begin
          next_s.mixer = req_i.wdata & demod_cfg_pkg::MASK_MIXER; // [R10]
        end
        demod_cfg_pkg::ADDR_CLK_DIV: begin
          next_s.clk_div = req_i.wdata & demod_cfg_pkg::MASK_CLK_DIV; // [R10]
        end
        demod_cfg_pkg::ADDR_DIG_PIN: begin
          next_s.dig_pin = req_i.wdata & demod_cfg_pkg::MASK_DIG_PIN; // [R10]
        end
        demod_cfg_pkg::ADDR_CORE_RESET: begin
          next_s.core_reset = req_i.wdata & demod_cfg_pkg::MASK_CORE_RESET; // [R10]
        end
        // Read-only registers drop writes
        demod_cfg_pkg::ADDR_CHIP_REV, demod_cfg_pkg::ADDR_CHECKSUM,
        demod_cfg_pkg::ADDR_BOOT_STATUS: begin
          next_s.checksum = s.checksum; // [R10]
        end
        default: begin
          if (coef_range) begin
            next_s.coef[coef_idx*8 +: 8] = req_i.wdata;
          end
        end
      endcase
    end
    // ***************************************************************
    // Boot result: checksum and status of the latest load
    // ***************************************************************
    if (boot_i.done) begin
      next_s.checksum = boot_i.checksum; // [R8]
      next_s.boot_status = {~boot_i.ok, boot_i.ok, ~boot_i.timeout}; // [R9]
    end
    // ***************************************************************
    // Register reads
    // ***************************************************************
    if (req_i.rd) begin
      unique case (req_i.addr)
        demod_cfg_pkg::ADDR_SERIAL_IF: next_s.rdata = s.serial_if;
        demod_cfg_pkg::ADDR_CHIP_REV: next_s.rdata = {4'h0, DIE_REVISION}; // [R10]
        demod_cfg_pkg::ADDR_COEF_STROBE: next_s.rdata = s.coef_strobe;
        demod_cfg_pkg::ADDR_ANALOG_PIN: next_s.rdata = s.analog_pin;
        demod_cfg_pkg::ADDR_SYNC_OUT: next_s.rdata = s.sync_out;
        demod_cfg_pkg::ADDR_MIXER: next_s.rdata = s.mixer;
        demod_cfg_pkg::ADDR_CLK_DIV: next_s.rdata = s.clk_div;
        demod_cfg_pkg::ADDR_DIG_PIN: next_s.rdata = s.dig_pin;
        demod_cfg_pkg::ADDR_CORE_RESET: next_s.rdata = s.core_reset;
        demod_cfg_pkg::ADDR_CHECKSUM: next_s.rdata = s.checksum; // [R8]
        demod_cfg_pkg::ADDR_BOOT_STATUS: next_s.rdata = {5'h00, s.boot_status}; // [R9] [R10]
        default: begin
          if (coef_range) begin
            next_s.rdata = s.coef[coef_idx*8 +: 8];
          end
        end
      endcase
    end
    // ***************************************************************
    // Soft reset hold: config at default until the reset bit is cleared
    // ***************************************************************
    if (hold_soft_reset) begin
      next_s.serial_if = s.serial_if; // [R1]
      next_s.coef_strobe = demod_cfg_pkg::RST_COEF_STROBE; // [R2]
      next_s.coef = demod_cfg_pkg::RST_COEF; // [R2]
      next_s.active_coef = demod_cfg_pkg::RST_COEF; // [R2]
      next_s.analog_pin = demod_cfg_pkg::RST_ANALOG_PIN; // [R2]
      next_s.sync_out = demod_cfg_pkg::RST_SYNC_OUT; // [R2]
      next_s.mixer = demod_cfg_pkg::RST_MIXER; // [R2]
      next_s.clk_div = demod_cfg_pkg::RST_CLK_DIV; // [R2]
      next_s.dig_pin = demod_cfg_pkg::RST_DIG_PIN; // [R2]
      next_s.core_reset = demod_cfg_pkg::RST_CORE_RESET; // [R2]
      next_s.coef_load = 1'b0;
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Same defaults as the soft reset; boot results start cleared
      s.serial_if <= demod_cfg_pkg::RST_SERIAL_IF;
      s.coef_strobe <= demod_cfg_pkg::RST_COEF_STROBE;
      s.coef <= demod_cfg_pkg::RST_COEF;
      s.active_coef <= demod_cfg_pkg::RST_COEF;
      s.analog_pin <= demod_cfg_pkg::RST_ANALOG_PIN;
      s.sync_out <= demod_cfg_pkg::RST_SYNC_OUT;
      s.mixer <= demod_cfg_pkg::RST_MIXER;
      s.clk_div <= demod_cfg_pkg::RST_CLK_DIV;
      s.dig_pin <= demod_cfg_pkg::RST_DIG_PIN;
      s.core_reset <= demod_cfg_pkg::RST_CORE_RESET;
      s.checksum <= 8'h00;
      s.boot_status <= 3'h0;
      s.rdata <= 8'h00;
      s.coef_load <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ***************************************************************
  // Read data and serial-interface controls
  // ***************************************************************
  assign rdata_o = s.rdata;
  assign soft_reset_o = s.serial_if[demod_cfg_pkg::SIF_SOFT_RESET]; // [R1]
  assign lsb_first_o = s.serial_if[demod_cfg_pkg::SIF_LSB_FIRST]; // [R3]
  assign addr_increment_o = s.serial_if[demod_cfg_pkg::SIF_ADDR_INC]; // [R4]
  assign four_wire_select_o = s.serial_if[demod_cfg_pkg::SIF_FOUR_WIRE]; // [R5]
  assign data_pin_bidir_o = ~s.serial_if[demod_cfg_pkg::SIF_FOUR_WIRE]; // [R5]

  // ***************************************************************
  // Configuration contents
  // ***************************************************************
  assign active_coef_o = s.active_coef;
  assign coef_load_o = s.coef_load;
  assign analog_pin_o = s.analog_pin;
  assign sync_out_o = s.sync_out;
  assign mixer_o = s.mixer;
  assign clk_div_o = s.clk_div;
  assign dig_pin_o = s.dig_pin;
  assign core_reset_o = s.core_reset[0];
endmodule
`default_nettype wire

/* testbench/demod_cfg_props.sv */
// Checker: concurrent assertions on the ports of the config register bank
`default_nettype none
module demod_cfg_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire demod_cfg_pkg::reg_req_t req_i,
  input wire demod_cfg_pkg::boot_result_t boot_i,
  input wire logic [7:0] rdata_o,
  input wire logic soft_reset_o,
  input wire logic lsb_first_o,
  input wire logic addr_increment_o,
  input wire logic four_wire_select_o,
  input wire logic data_pin_bidir_o,
  input wire logic coef_load_o,
  input wire logic [7:0] mixer_o,
  input wire logic [7:0] sync_out_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence sif_write;
    req_i.wr && req_i.addr == 15'h0000;
  endsequence
  sequence boot_then_status;
    boot_i.done ##1 (req_i.rd && req_i.addr == 15'h002F);
  endsequence
  sequence boot_then_sum;
    boot_i.done ##1 (req_i.rd && req_i.addr == 15'h002E);
  endsequence
  chk_sif_fields: assert property (sif_write |=>
    {soft_reset_o, lsb_first_o, addr_increment_o, four_wire_select_o} == $past(req_i.wdata[7:4]))
    else $error("serial fields wrong");
  chk_bidir_inverse: assert property (data_pin_bidir_o == !four_wire_select_o)
    else $error("data pin mode wrong");
  chk_sif_mirror: assert property (req_i.rd && req_i.addr == 15'h0000 |=>
    rdata_o[3:0] == {rdata_o[4], rdata_o[5], rdata_o[6], rdata_o[7]}) else $error("no mirror");
  chk_soft_defaults: assert property (soft_reset_o && $past(soft_reset_o) |->
    mixer_o == 8'h18 && sync_out_o == 8'h2D) else $error("defaults lost in reset");
  chk_load_cause: assert property (coef_load_o && !soft_reset_o |->
    $past(req_i.wr && req_i.addr == 15'h0010 && req_i.wdata[1:0] != 2'h0))
    else $error("load without strobe");
  chk_load_pulse: assert property (coef_load_o |=> !coef_load_o)
    else $error("load pulse too long");
  chk_boot_status: assert property (boot_then_status |=>
    rdata_o == {5'h00, ~$past(boot_i.ok, 2), $past(boot_i.ok, 2), ~$past(boot_i.timeout, 2)})
    else $error("boot status wrong");
  chk_boot_sum: assert property (boot_then_sum |=> rdata_o == $past(boot_i.checksum, 2))
    else $error("checksum wrong");
  chk_rev_upper: assert property (req_i.rd && req_i.addr == 15'h0006 |=>
    rdata_o[7:4] == 4'h0) else $error("revision upper bits set");
endmodule
`default_nettype wire

/* testbench/serial_host_model.sv */
// Partner model: serial host issuing single-byte register reads and writes
`default_nettype none
module serial_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output var demod_cfg_pkg::reg_req_t req_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial req_o = '0;
  // Bytes go whole; bit order on the wire is the front end's job
  task automatic write(input logic [14:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    #1;
  endtask
  task automatic read(input logic [14:0] a, output logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    #1 d = rdata_i;
  endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Testbench: scenario tasks for the config register bank
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] REV = 4'h9; // Arbitrary value
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  demod_cfg_pkg::reg_req_t req;
  demod_cfg_pkg::boot_result_t boot = '0;
  logic [7:0] rdata, sync_out, mixer, clk_div, dig_pin, analog_pin;
  logic [demod_cfg_pkg::NUM_COEF*8-1:0] coef;
  logic soft_rst, lsb, inc, four, bidir, load, core;
  int err_count = 0;
  int comparisons = 0;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (boot.done) boot.done <= 1'b0;
  serial_host_model host (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));
  demod_config_register_bank #(.DIE_REVISION(REV)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .req_i(req), .boot_i(boot), .rdata_o(rdata), .soft_reset_o(soft_rst), .lsb_first_o(lsb),
    .addr_increment_o(inc), .four_wire_select_o(four), .data_pin_bidir_o(bidir),
    .active_coef_o(coef), .coef_load_o(load), .analog_pin_o(analog_pin),
    .sync_out_o(sync_out), .mixer_o(mixer), .clk_div_o(clk_div), .dig_pin_o(dig_pin),
    .core_reset_o(core));
  task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.read(a, d);
    `CHK($sformatf("reg %h", a), e, d)
  endtask
  task automatic t_defaults();
    rd_chk(15'h0000, 8'h00);
    rd_chk(15'h0029, 8'h2D);
    rd_chk(15'h002A, 8'h18);
    rd_chk(15'h002B, 8'h02);
    rd_chk(15'h002C, 8'h01);
    rd_chk(15'h0006, {4'h0, REV});
    rd_chk(15'h0013, 8'h1D);
    rd_chk(15'h0024, 8'hE0);
    `CHK("active coef", 16'hE01D, {coef[159:152], coef[23:16]})
    `CHK("sync", 8'h2D, sync_out)
    `CHK("mixer", 8'h18, mixer)
    `CHK("clk div", 8'h02, clk_div)
    `CHK("dig pin", 8'h01, dig_pin)
    `CHK("analog", 8'h00, analog_pin)
    `CHK("core reset", 1'b0, core)
    `CHK("load", 1'b0, load)
  endtask
  task automatic t_serial_if();
    logic [7:0] v[5] = '{8'h40, 8'h20, 8'h10, 8'h0F, 8'h00};
    foreach (v[i]) begin
      host.write(15'h0000, v[i]);
      `CHK("modes", {v[i][6:4], ~v[i][4]}, {lsb, inc, four, bidir})
      rd_chk(15'h0000, {v[i][7:4], v[i][4], v[i][5], v[i][6], v[i][7]});
    end
  endtask
  task automatic t_soft_reset();
    host.write(15'h002A, 8'h5F);
    `CHK("mixer", 8'h5F, mixer)
    host.write(15'h0013, 8'h55);
    rd_chk(15'h0013, 8'h55);
    host.write(15'h0000, 8'h80);
    `CHK("soft reset", 1'b1, soft_rst)
    host.write(15'h002A, 8'h00);
    rd_chk(15'h002A, 8'h18);
    rd_chk(15'h0000, 8'h81);
    host.write(15'h0000, 8'h00);
    `CHK("soft reset", 1'b0, soft_rst)
    rd_chk(15'h002A, 8'h18);
    rd_chk(15'h0013, 8'h1D);
  endtask
  task automatic t_coef_load();
    host.write(15'h0011, 8'hA5);
    host.write(15'h0027, 8'h3C);
    host.write(15'h0010, 8'h01);
    `CHK("load", 1'b1, load)
    `CHK("coef", 16'h3CA5, {coef[183:176], coef[7:0]})
    host.write(15'h0011, 8'h00);
    host.write(15'h0010, 8'h02);
    `CHK("load", 1'b0, load)
    host.write(15'h0010, 8'h00);
    host.write(15'h0010, 8'h03);
    `CHK("coef", 8'h00, coef[7:0])
    rd_chk(15'h0010, 8'h03);
  endtask
  task automatic t_unused();
    host.write(15'h0028, 8'hFF);
    rd_chk(15'h0028, 8'h03);
    `CHK("analog", 8'h03, analog_pin)
    host.write(15'h0029, 8'hFF);
    `CHK("sync", 8'h3F, sync_out)
    host.write(15'h002B, 8'hFF);
    `CHK("clk div", 8'h1F, clk_div)
    host.write(15'h002C, 8'h00);
    `CHK("dig pin", 8'h00, dig_pin)
    host.write(15'h002D, 8'hFF);
    `CHK("core reset", 1'b1, core)
    host.write(15'h0006, 8'hFF);
    rd_chk(15'h0006, {4'h0, REV});
    host.write(15'h0050, 8'hFF);
    rd_chk(15'h0050, 8'h00);
  endtask
  task automatic t_boot();
    @(posedge clk_i);
    boot <= '{done: 1'b1, checksum: 8'h5A, ok: 1'b1, timeout: 1'b0};
    rd_chk(15'h002E, 8'h5A);
    rd_chk(15'h002F, 8'h03);
    @(posedge clk_i);
    boot <= '{done: 1'b1, checksum: 8'hC3, ok: 1'b0, timeout: 1'b1};
    rd_chk(15'h002F, 8'h04);
    rd_chk(15'h002E, 8'hC3);
  endtask
  task automatic t_hw_reset();
    host.write(15'h002A, 8'h00);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(15'h002E, 8'h00);
    rd_chk(15'h002F, 8'h00);
    rd_chk(15'h0010, 8'h00);
    rd_chk(15'h002A, 8'h18);
    `CHK("mixer", 8'h18, mixer)
    `CHK("sync", 8'h2D, sync_out)
    `CHK("clk div", 8'h02, clk_div)
    `CHK("dig pin", 8'h01, dig_pin)
    `CHK("core reset", 1'b0, core)
  endtask
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_defaults();
    t_serial_if();
    t_soft_reset();
    t_coef_load();
    t_unused();
    t_boot();
    t_hw_reset();
    tally_and_finish();
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    err_count++;
    tally_and_finish();
  end
endmodule
bind demod_config_register_bank demod_cfg_props props (.clk_i, .rst_i, .req_i, .boot_i,
  .rdata_o, .soft_reset_o, .lsb_first_o, .addr_increment_o, .four_wire_select_o,
  .data_pin_bidir_o, .coef_load_o, .mixer_o, .sync_out_o);
`default_nettype wire
